// ==== hdl/swh_ctrl.sv ====
// power mode controller: sleep, wakeup with pll restart, cpu halt
// assumes cpu issues one-cycle commands and clears its interrupt itself
`timescale 1ns/1ps
module swh_ctrl
#(
	parameter int LOCK_CYC = swh_pkg::SWH_LOCK_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// cpu commands (one-cycle pulses)
	input wire logic sleep_cmd,
	input wire logic halt_cmd,
	input wire logic int_ack,
	// wakeup enables and sources
	input wire logic [swh_pkg::SWH_NSRC-1:0] wake_en,
	input wire logic timer_a_int,
	input wire logic timer_b_int,
	input wire logic timer_c_int,
	input wire logic external_interrupt_one,
	input wire logic external_interrupt_two,
	input wire logic rtc_int,
	// key wakeup
	input wire logic key_arm,
	input wire logic [swh_pkg::SWH_KEY_W-1:0] key_port,
	// pending interrupts for halt exit
	input wire logic irq_pending,
	// clock gating and cpu signals
	output logic pll_en,
	output logic cpu_clk_en,
	output logic sleeping,
	output logic wake_int,
	output logic [swh_pkg::SWH_NSRC-1:0] wake_cause
);
	import swh_pkg::*;
	typedef struct packed {
		swh_state_t state;
		logic [SWH_CNT_W-1:0] cnt;
		logic pll_en;
		logic cpu_clk_en;
		logic sleeping;
		logic wake_int;
		logic [SWH_NSRC-1:0] cause;
	} swh_st_t;
	swh_st_t st_q, st_d;
	logic key_change;
	logic [SWH_NSRC-1:0] src;
	logic [SWH_NSRC-1:0] hit;
	// key change detection on the upper port a byte
	swh_key_detect u_key
	(
		.clk(clk),
		.srst(srst),
		.arm(key_arm),
		.port_in(key_port),
		.change(key_change)
	);
	// [R5] the full wakeup source set
	always_comb
	begin
		src = '0;
		src[SWH_SRC_TMA] = timer_a_int;
		src[SWH_SRC_TMB] = timer_b_int;
		src[SWH_SRC_TMC] = timer_c_int;
		src[SWH_SRC_EXT_ONE] = external_interrupt_one;
		src[SWH_SRC_EXT_TWO] = external_interrupt_two;
		src[SWH_SRC_KEY] = key_change;
		src[SWH_SRC_RTC] = rtc_int;
		hit = src & wake_en;
	end
	// mode sequencer; lock counter width covers the default wait
	always_comb
	begin
		st_d = st_q;
		case (st_q.state)
			SWH_RUN:
			begin
				// [R1] stay running until sleep or halt requested
				if (sleep_cmd)
				begin
					// [R2] stop pll first
					st_d.pll_en = 1'b0;
					st_d.cpu_clk_en = 1'b0;
					st_d.state = SWH_PLL_OFF;
				end
				else if (halt_cmd)
				begin
					// [R6] gate cpu clock only
					st_d.cpu_clk_en = 1'b0;
					st_d.state = SWH_HALT;
				end
			end
			SWH_PLL_OFF:
			begin
				// [R2] pll is off, now asleep
				st_d.sleeping = 1'b1;
				st_d.state = SWH_SLEEP;
			end
			SWH_SLEEP:
			begin
				// [R3] only an enabled source restarts the pll
				if (|hit)
				begin
					st_d.pll_en = 1'b1;
					st_d.cause = hit;
					st_d.cnt = SWH_CNT_W'(LOCK_CYC);
					st_d.state = SWH_PLL_LOCK;
				end
			end
			SWH_PLL_LOCK:
			begin
				// wait for pll to settle before the cpu sees a clock
				if (st_q.cnt <= SWH_CNT_W'(1))
				begin
					st_d.cnt = '0;
					st_d.cpu_clk_en = 1'b1;
					st_d.sleeping = 1'b0;
					// [R4] request fiq/irq to finish wakeup
					st_d.wake_int = 1'b1;
					st_d.state = SWH_WAKE_INT;
				end
				else
					st_d.cnt = st_q.cnt - SWH_CNT_W'(1);
			end
			SWH_WAKE_INT:
			begin
				// [R4] hold request until cpu acknowledges
				if (int_ack)
				begin
					st_d.wake_int = 1'b0;
					st_d.state = SWH_RUN;
				end
			end
			SWH_HALT:
			begin
				// [R8] pending interrupt resumes the cpu
				if (irq_pending || (|hit))
				begin
					st_d.cpu_clk_en = 1'b1;
					st_d.state = SWH_RUN;
				end
			end
			default:
				st_d.state = SWH_RUN;
		endcase
	end
	// register the whole state; reset leaves the chip running
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q.state <= SWH_RUN;
			st_q.cnt <= '0;
			st_q.pll_en <= 1'b1;
			st_q.cpu_clk_en <= 1'b1;
			st_q.sleeping <= 1'b0;
			st_q.wake_int <= 1'b0;
			st_q.cause <= '0;
		end
		else
			st_q <= st_d;
	end
	assign pll_en = st_q.pll_en;
	assign cpu_clk_en = st_q.cpu_clk_en;
	assign sleeping = st_q.sleeping;
	assign wake_int = st_q.wake_int;
	assign wake_cause = st_q.cause;
	sequence sleep_req_s;
		st_q.state == SWH_RUN && sleep_cmd;
	endsequence
	sequence pll_down_s;
		!pll_en && !sleeping ##1 !pll_en && sleeping;
	endsequence
	// [R1] running while idle
	run_clocks_a: assert property (@(posedge clk) disable iff (srst) // [R1]
		st_q.state == SWH_RUN |-> pll_en && cpu_clk_en)
		else $error("clocks off while running");
	// [R2] pll stops before sleep
	sleep_order_a: assert property (@(posedge clk) disable iff (srst) // [R2]
		sleep_req_s |=> pll_down_s)
		else $error("sleep entry order wrong");
	// [R2] cpu stays gated while asleep or locking
	sleep_gate_a: assert property (@(posedge clk) disable iff (srst) // [R2]
		sleeping |-> !cpu_clk_en)
		else $error("cpu clock running while asleep");
	// [R3] no pll restart without source
	sleep_hold_a: assert property (@(posedge clk) disable iff (srst) // [R3]
		st_q.state == SWH_SLEEP && hit == '0 |=> !pll_en)
		else $error("pll restarted without wakeup");
	wake_pll_a: assert property (@(posedge clk) disable iff (srst) // [R3]
		st_q.state == SWH_SLEEP && hit != '0 |=> pll_en && !cpu_clk_en)
		else $error("pll not restarted on wakeup");
	// [R4] interrupt after lock
	wake_irq_a: assert property (@(posedge clk) disable iff (srst) // [R4]
		$rose(pll_en) |-> ##[1:300] wake_int)
		else $error("no wake interrupt after restart");
	// [R4] request stands until the cpu answers
	wake_hold_a: assert property (@(posedge clk) disable iff (srst) // [R4]
		wake_int && !int_ack |=> wake_int)
		else $error("wake interrupt dropped early");
	// [R5] cause only names enabled sources
	wake_cause_a: assert property (@(posedge clk) disable iff (srst) // [R5]
		st_q.state == SWH_SLEEP && hit != '0 |=> wake_cause == $past(hit))
		else $error("wake cause mismatch");
	// [R5] cause is frozen through the lock wait
	cause_hold_a: assert property (@(posedge clk) disable iff (srst) // [R5]
		st_q.state == SWH_PLL_LOCK |=> $stable(wake_cause))
		else $error("wake cause changed while locking");
	// [R6] halt keeps pll
	halt_pll_a: assert property (@(posedge clk) disable iff (srst) // [R6]
		st_q.state == SWH_HALT |-> pll_en && !cpu_clk_en)
		else $error("halt clocks wrong");
	// [R8] halt exit on pending
	halt_exit_a: assert property (@(posedge clk) disable iff (srst) // [R8]
		st_q.state == SWH_HALT && irq_pending |=> cpu_clk_en)
		else $error("halt not left on interrupt");
	// [R8] an enabled wake source ends halt as well
	halt_wake_a: assert property (@(posedge clk) disable iff (srst) // [R8]
		st_q.state == SWH_HALT && hit != '0 |=> cpu_clk_en)
		else $error("halt not left on wakeup source");
endmodule

// ==== inc/swh_pkg.sv ====
// sleep / wakeup / halt control: shared constants and state type
// assumes one 25 MHz clock and a synchronous active-high reset
// Functional notes
// [R1] after reset the system clock runs until software issues sleep
// [R2] accepted sleep first stops the pll, then enters the sleep state
// [R3] in sleep only an asserted enabled wakeup source restarts the pll
// [R4] after clock restart an fiq or irq request goes to the cpu
// [R5] wakeup sources: timers a b c, external one and two, key change, rtc
// [R6] halt gates only the cpu clock, the pll keeps running
// [R7] key change latches port a upper byte when armed, wakes on difference
// [R8] halt ends when any enabled interrupt request becomes pending
package swh_pkg;
	// wakeup source bit positions
	localparam int SWH_SRC_TMA = 0;
	localparam int SWH_SRC_TMB = 1;
	localparam int SWH_SRC_TMC = 2;
	localparam int SWH_SRC_EXT_ONE = 3;
	localparam int SWH_SRC_EXT_TWO = 4;
	localparam int SWH_SRC_KEY = 5;
	localparam int SWH_SRC_RTC = 6;
	localparam int SWH_NSRC = 7;
	// key port width (upper byte of port a)
	localparam int SWH_KEY_W = 8;
	// pll lock wait after restart
	localparam int SWH_LOCK_NS = 2000;
	localparam int SWH_CLK_NS = 40;
	localparam int SWH_LOCK_CYC = (SWH_LOCK_NS + SWH_CLK_NS - 1) / SWH_CLK_NS;
	localparam int SWH_CNT_W = 8;
	localparam logic [SWH_KEY_W-1:0] SWH_KEY_RST = 8'h00;
	typedef enum logic [2:0] {
		SWH_RUN,
		SWH_PLL_OFF,
		SWH_SLEEP,
		SWH_PLL_LOCK,
		SWH_WAKE_INT,
		SWH_HALT
	} swh_state_t;
endpackage

// ==== hdl/swh_key_detect.sv ====
// key change detector: snapshot of port a upper byte, flags difference
// assumes port pins already synchronous to clk
`timescale 1ns/1ps
module swh_key_detect
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// key port
	input wire logic arm,
	input wire logic [swh_pkg::SWH_KEY_W-1:0] port_in,
	// result
	output logic change
);
	import swh_pkg::*;
	typedef struct packed {
		logic [SWH_KEY_W-1:0] snap;
		logic armed;
		logic change;
	} swh_key_st_t;
	swh_key_st_t st_q, st_d;
	// next state: snapshot on arm, compare otherwise
	always_comb
	begin
		st_d = st_q;
		// [R7] latch then compare
		if (arm)
		begin
			st_d.snap = port_in;
			st_d.armed = 1'b1;
			st_d.change = 1'b0;
		end
		else
			st_d.change = st_q.armed && (port_in != st_q.snap);
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q.snap <= SWH_KEY_RST;
			st_q.armed <= 1'b0;
			st_q.change <= 1'b0;
		end
		else
			st_q <= st_d;
	end
	assign change = st_q.change;
	// key change follows a mismatch by one cycle
	key_change_a: assert property (@(posedge clk) disable iff (srst) // [R7]
		st_q.armed && !arm && port_in != st_q.snap |=> change)
		else $error("key change not flagged");
endmodule

// ==== test/swh_cpu_model.sv ====
// cpu stand-in: answers the wake interrupt after a chosen delay
// assumes wake_int is a level held until int_ack is seen
`timescale 1ns/1ps
module swh_cpu_model
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// interrupt handshake
	input wire logic [3:0] ack_dly,
	input wire logic wake_int,
	output logic int_ack
);
	logic [3:0] cnt_q;
	always_ff @(posedge clk)
	begin
		if (srst || !wake_int || int_ack)
		begin
			cnt_q <= 4'h0;
			int_ack <= 1'b0;
		end
		else if (cnt_q >= ack_dly)
			int_ack <= 1'b1;
		else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule

// ==== test/tb_sleep_wakeup_halt_control.sv ====
// bench for the power mode controller with a short pll lock wait
// assumes the cpu model answers wake_int on its own
`timescale 1ns/1ps
module tb_sleep_wakeup_halt_control;
	import swh_pkg::*;
	localparam int LK = 3;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic sleep_cmd = 1'b0;
	logic halt_cmd = 1'b0;
	logic key_arm = 1'b0;
	logic irq_pending = 1'b0;
	logic int_ack, pll_en, cpu_clk_en, sleeping, wake_int;
	logic [6:0] wake_en = 7'h00;
	logic [6:0] src = 7'h00;
	logic [6:0] cause;
	logic [7:0] key_port = 8'h00;
	logic [7:0] ksnap;
	logic [3:0] ack_dly = 4'h0;
	int n_mismatch = 0;
	int n_tests = 0;
	int k;
	// free-running clock
	always #20 clk = ~clk;
	swh_ctrl #(.LOCK_CYC(LK)) u_dut (.clk(clk), .srst(srst), .sleep_cmd(sleep_cmd),
		.halt_cmd(halt_cmd), .int_ack(int_ack), .wake_en(wake_en), .timer_a_int(src[0]),
		.timer_b_int(src[1]), .timer_c_int(src[2]), .external_interrupt_one(src[3]),
		.external_interrupt_two(src[4]), .rtc_int(src[6]), .key_arm(key_arm),
		.key_port(key_port), .irq_pending(irq_pending), .pll_en(pll_en),
		.cpu_clk_en(cpu_clk_en), .sleeping(sleeping), .wake_int(wake_int), .wake_cause(cause));
	swh_cpu_model u_cpu (.clk(clk), .srst(srst), .ack_dly(ack_dly), .wake_int(wake_int),
		.int_ack(int_ack));
	// one-hot cause expected from a single source
	function automatic logic [6:0] exp_cause(input int i);
		return 7'h01 << i;
	endfunction
	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("Error %0t flag %b expected %b", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic chk7(input logic [6:0] got, input logic [6:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("Error %0t cause %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	// bounded wait: 0 pll on, 1 wake_int up, 2 wake_int down
	task automatic wait_on(input int sel, input int lim);
		k = 0;
		while (k < lim && (sel == 0 ? pll_en : sel == 1 ? wake_int : !wake_int) !== 1'b1)
		begin
			@(negedge clk);
			k++;
		end
		chk1(k < lim, 1'b1);
	endtask
	task automatic give_verdict;
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// watchdog, far beyond the expected run
	initial
	begin
		#200000;
		n_mismatch++;
		give_verdict();
	end
	// main sequence, inputs move on the falling edge
	initial
	begin
		void'($urandom(25266));
		repeat (3) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		chk1(pll_en & cpu_clk_en & !sleeping & !wake_int, 1'b1);
		for (int i = 0; i < SWH_NSRC; i++)
		begin
			wake_en = 7'($urandom) & ~exp_cause(i);
			ksnap = 8'($urandom);
			key_port = ksnap;
			// re-arm every round so an old snapshot cannot wake this one
			key_arm = 1'b1;
			sleep_cmd = 1'b1;
			@(negedge clk);
			sleep_cmd = 1'b0;
			key_arm = 1'b0;
			chk1(pll_en, 1'b0);
			chk1(sleeping, 1'b0);
			@(negedge clk);
			chk1(sleeping, 1'b1);
			// source raised while still disabled must not wake
			if (i == 5)
				key_port = ksnap ^ (8'($urandom) | 8'h01);
			else
				src[i] = 1'b1;
			repeat (3) @(negedge clk);
			chk1(pll_en, 1'b0);
			wake_en = wake_en | exp_cause(i);
			wait_on(0, 4);
			chk7(cause, exp_cause(i));
			chk1(cpu_clk_en, 1'b0);
			wait_on(1, LK + 3);
			chk1(k == LK, 1'b1);
			chk1(cpu_clk_en & !sleeping, 1'b1);
			src = 7'h00;
			key_port = ksnap;
			ack_dly = 4'($urandom);
			wait_on(2, 24);
		end
		// halt keeps the pll, waits for a pending request
		wake_en = 7'h00;
		halt_cmd = 1'b1;
		@(negedge clk);
		halt_cmd = 1'b0;
		chk1(cpu_clk_en, 1'b0);
		chk1(pll_en, 1'b1);
		repeat (3) @(negedge clk);
		chk1(cpu_clk_en, 1'b0);
		irq_pending = 1'b1;
		@(negedge clk);
		irq_pending = 1'b0;
		chk1(cpu_clk_en, 1'b1);
		// an enabled wake source ends halt as well
		wake_en = exp_cause(SWH_SRC_RTC);
		halt_cmd = 1'b1;
		@(negedge clk);
		halt_cmd = 1'b0;
		chk1(cpu_clk_en, 1'b0);
		src[SWH_SRC_RTC] = 1'b1;
		@(negedge clk);
		src = 7'h00;
		chk1(cpu_clk_en, 1'b1);
		give_verdict();
	end
endmodule
